// ### common/avw_pkg.sv
/*
  package for the write-only two-wire volume slave: address, register
  layout, reset value, bits per byte and link timing constants.
  assumes a 10 MHz system clock that oversamples the serial clock pin.
*/
package avw_pkg;

  // fixed 7-bit slave address
  localparam logic [6:0] SLAVE_ADDR      = 7'h76;
  // register field positions
  localparam int         GAIN_MSB        = 7;
  localparam int         GAIN_LSB        = 3;
  localparam int         RSVD_BIT        = 2;
  localparam int         EN_A_BIT        = 1;
  localparam int         EN_B_BIT        = 0;
  // value after reset: gain code 0, both enables off
  localparam logic [7:0] REG_RESET       = 8'h00;
  // bits per byte before the acknowledge slot
  localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
  // link timing
  localparam int         SCL_MAX_KHZ     = 400;
  localparam int         SYS_CLK_KHZ     = 10000;
  localparam int         SYS_PER_SCL_MIN = SYS_CLK_KHZ / SCL_MAX_KHZ;

  // register contents as stored
  typedef struct packed {
    logic [4:0] gain_code;
    logic       reserved_zero;
    logic       enable_a;
    logic       enable_b;
  } avw_reg_type;

  // sampled pin pair after synchronisers
  typedef struct packed {
    logic scl;
    logic sda;
  } avw_pins_type;

  // protocol states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_DATA,
    ST_DATA_ACK,
    ST_IGNORE
  } avw_state_type;

endpackage : avw_pkg

// ### logic/avw_slave.sv
/*
  write-only two-wire slave holding one gain and enable register, with
  gain decode to signed dB and shutdown output.
  assumes scl and sda come from another domain and are synchronised
  here; the bus master makes every clock pulse.
*/
// Functional notes
// - works with serial clock up to 400 kHz
// - never drives clock; pulls data only low
// - start condition begins transfer, expect address
// - eight bits then a ninth acknowledge pulse
// - address msb first, then direction, zero writes
// - acknowledge only matching address 1110110
// - sample data on rising clock edge
// - read direction gets no acknowledge, stays released
// - one data byte acknowledged after address
// - store gain code, reserved zero, two enables
// - codes 0 to 15 map negative gains
// - codes 16 to 31 map 0 to 24
// - both enables zero means shutdown, keep contents
// - reset clears register and ignores traffic
`timescale 1ns/1ns
module avw_slave (
  input  wire logic                clk_sys,       // 10 MHz system clock
  input  wire logic                reset_n,       // synchronous reset
  input  wire logic                scl_in,        // serial clock pin
  input  wire logic                sda_in,        // data pin level
  output logic                     sda_out,       // data drive value
  output logic                     sda_oe,        // high while pulling low
  output logic [4:0]               gain_code,     // stored gain code
  output logic signed [7:0]        gain_db,       // decoded gain in dB
  output logic                     amp_enable_a,  // first enable
  output logic                     amp_enable_b,  // second enable
  output logic                     amp_shutdown,  // both enables off
  output logic                     amp_running    // both enables on
);

  ////////////////////////////////////////////////////////////////////////
  // gain decode table
  ////////////////////////////////////////////////////////////////////////

  // maps a 5-bit code to its gain in dB
  function automatic logic signed [7:0] gain_of(input logic [4:0] code);
    logic signed [7:0] g;
    g = 8'sh00;
    unique case (code)
      5'h00: g = -8'sd70;
      5'h01: g = -8'sd56;
      5'h02: g = -8'sd46;
      5'h03: g = -8'sd38;
      5'h04: g = -8'sd32;
      5'h05: g = -8'sd28;
      5'h06: g = -8'sd24;
      5'h07: g = -8'sd21;
      5'h08: g = -8'sd18;
      5'h09: g = -8'sd15;
      5'h0A: g = -8'sd12;
      5'h0B: g = -8'sd10;
      5'h0C: g = -8'sd8;
      5'h0D: g = -8'sd6;
      5'h0E: g = -8'sd4;
      5'h0F: g = -8'sd2;
      5'h10: g = 8'sd0;
      5'h11: g = 8'sd2;
      5'h12: g = 8'sd4;
      5'h13: g = 8'sd6;
      5'h14: g = 8'sd8;
      5'h15: g = 8'sd10;
      5'h16: g = 8'sd12;
      5'h17: g = 8'sd14;
      5'h18: g = 8'sd16;
      5'h19: g = 8'sd18;
      5'h1A: g = 8'sd19;
      5'h1B: g = 8'sd20;
      5'h1C: g = 8'sd21;
      5'h1D: g = 8'sd22;
      5'h1E: g = 8'sd23;
      5'h1F: g = 8'sd24;
    endcase
    return g;
  endfunction : gain_of

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  ////////////////////////////////////////////////////////////////////////

  // both pins come from the master's side and are not tied to clk_sys;
  // two flops keep a metastable level away from the edge detectors.
  // at 10 MHz a 400 kHz serial clock is sampled about twelve times per
  // half period, while the engine needs only three samples per level
  avw_pkg::avw_pins_type meta_q, meta_d;   // first stage, read by sync only
  avw_pkg::avw_pins_type sync_q, sync_d;   // second stage
  avw_pkg::avw_pins_type prev_q, prev_d;   // previous synced sample

  // next values of the synchroniser chain
  always_comb
  begin
    meta_d = '{scl: scl_in, sda: sda_in};
    sync_d = meta_q;
    prev_d = sync_q;
  end

  // register the chain; idle bus is high
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      meta_q <= '{scl: 1'b1, sda: 1'b1};
      sync_q <= '{scl: 1'b1, sda: 1'b1};
      prev_q <= '{scl: 1'b1, sda: 1'b1};
    end
    else
    begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // edge and condition detectors on synced samples
  logic scl_rise;   // serial clock rising edge
  logic scl_fall;   // serial clock falling edge
  logic start_seen; // data falls while clock high
  logic stop_seen;  // data rises while clock high

  // the previous sample resets to the idle level, so no false edge
  // or start shows up in the first cycles after reset
  assign scl_rise   = sync_q.scl & ~prev_q.scl;
  assign scl_fall   = ~sync_q.scl & prev_q.scl;
  assign start_seen = sync_q.scl & prev_q.scl
                      & prev_q.sda & ~sync_q.sda;
  // a stop drops the frame wherever it stands; a start restarts it
  assign stop_seen  = sync_q.scl & prev_q.scl
                      & ~prev_q.sda & sync_q.sda;

  ////////////////////////////////////////////////////////////////////////
  // protocol engine
  ////////////////////////////////////////////////////////////////////////

  avw_pkg::avw_state_type state_q, state_d;   // protocol state
  logic [3:0]             bit_cnt_q, bit_cnt_d; // bits taken this byte
  logic [7:0]             shift_q, shift_d;   // incoming byte
  logic                   ack_q, ack_d;       // pulling data low
  logic [7:0]             reg_q, reg_d;       // gain and enable register
  logic [7:0]             rx_byte;            // byte incl. current bit

  // rx_byte folds in the bit sampled now, so that the shift and the
  // count move together on the same rising edge
  assign rx_byte = {shift_q[6:0], sync_q.sda};

  // next state, shift, acknowledge drive and register write
  always_comb
  begin
    state_d   = state_q;
    bit_cnt_d = bit_cnt_q;
    shift_d   = shift_q;
    ack_d     = ack_q;
    reg_d     = reg_q;
    if (start_seen)
    begin
      // a start, repeated or not, restarts the address phase
      state_d   = avw_pkg::ST_ADDR;
      bit_cnt_d = 4'h0;
      ack_d     = 1'b0;
    end
    else if (stop_seen)
    begin
      state_d = avw_pkg::ST_IDLE;
      ack_d   = 1'b0;
    end
    else
    begin
      unique case (state_q)
        avw_pkg::ST_IDLE,
        avw_pkg::ST_IGNORE:
        begin
          // wait for a start; clock edges alone do nothing here
          ack_d = 1'b0;
        end
        avw_pkg::ST_ADDR,
        avw_pkg::ST_DATA:
        begin
          if (scl_rise)
          begin
            // shift msb first on each rising edge
            shift_d   = rx_byte;
            bit_cnt_d = bit_cnt_q + 4'h1;
          end
          else if (scl_fall && bit_cnt_q == avw_pkg::BITS_PER_BYTE)
          begin
            // the acknowledge starts on the fall after the eighth bit,
            // so the data line only moves while the serial clock is low
            bit_cnt_d = 4'h0;
            if (state_q == avw_pkg::ST_ADDR)
            begin
              // match address and write direction
              if (shift_q[7:1] == avw_pkg::SLAVE_ADDR
                  && !shift_q[0])
              begin
                ack_d   = 1'b1;
                state_d = avw_pkg::ST_ADDR_ACK;
              end
              else
              begin
                state_d = avw_pkg::ST_IGNORE;
              end
            end
            else
            begin
              // store the data byte, reserved bit forced to zero
              reg_d           = shift_q;
              reg_d[avw_pkg::RSVD_BIT] = 1'b0;
              ack_d           = 1'b1;
              state_d         = avw_pkg::ST_DATA_ACK;
            end
          end
        end
        avw_pkg::ST_ADDR_ACK:
        begin
          // release after the ninth pulse
          if (scl_fall)
          begin
            ack_d   = 1'b0;
            state_d = avw_pkg::ST_DATA;
          end
        end
        avw_pkg::ST_DATA_ACK:
        begin
          // only one data byte; further bytes are ignored
          if (scl_fall)
          begin
            ack_d   = 1'b0;
            state_d = avw_pkg::ST_IGNORE;
          end
        end
      endcase
    end
  end

  // register the engine; reset clears the register and drops traffic
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      state_q   <= avw_pkg::ST_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      ack_q     <= 1'b0;
      reg_q     <= avw_pkg::REG_RESET;
    end
    else
    begin
      state_q   <= state_d;
      bit_cnt_q <= bit_cnt_d;
      shift_q   <= shift_d;
      ack_q     <= ack_d;
      reg_q     <= reg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  ////////////////////////////////////////////////////////////////////////

  // all register outputs come straight from flops; the status pair is
  // a plain decode of the two stored enables
  avw_pkg::avw_reg_type fields;   // register viewed as fields
  assign fields = avw_pkg::avw_reg_type'(reg_q);

  // open-drain data: drive only low, clock never driven
  assign sda_out      = 1'b0;
  assign sda_oe       = ack_q;
  assign gain_code    = fields.gain_code;
  assign amp_enable_a = fields.enable_a;
  assign amp_enable_b = fields.enable_b;
  // shutdown keeps contents; gain returns on re-enable
  assign amp_shutdown = ~fields.enable_a & ~fields.enable_b;
  assign amp_running  = fields.enable_a & fields.enable_b;

  // decoded gain registered as a data output
  logic signed [7:0] gain_db_q, gain_db_d;
  // decode the stored code; the table covers every code
  always_comb
  begin
    gain_db_d = gain_of(fields.gain_code);
  end
  // register the decoded gain; it trails gain_code by one cycle, and
  // reset gives the lowest step, matching the cleared code
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      gain_db_q <= -8'sd70;
    end
    else
    begin
      gain_db_q <= gain_db_d;
    end
  end
  assign gain_db = gain_db_q;

endmodule : avw_slave

// ### bench/avw_slave_sva.sv
/*
  checker for the volume slave: ack timing, register update, reset.
  assumes one clk_sys domain and binding to avw_slave ports.
*/
`timescale 1ns/1ns
module avw_slave_sva (
  input wire logic       clk_sys,
  input wire logic       reset_n,
  input wire logic       scl_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic [4:0] gain_code,
  input wire logic       amp_enable_a,
  input wire logic       amp_enable_b,
  input wire logic       amp_shutdown,
  input wire logic       amp_running
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  a_out_low: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("ack started with clock high");
  a_ack_holds: assert property ($rose(sda_oe) |-> sda_oe [*3])
    else $error("ack pulse too short");
  a_reg_on_ack: assert property (
    $changed({gain_code, amp_enable_a, amp_enable_b}) |-> $rose(sda_oe))
    else $error("register changed outside data ack");
  a_reset_clear: assert property (!$past(reset_n) |->
    gain_code == 5'h00 && !amp_enable_a && !amp_enable_b)
    else $error("register not cleared by reset");
  a_reset_no_ack: assert property (!$past(reset_n) |-> !sda_oe)
    else $error("ack driven during reset");
  a_shutdown_map: assert property (
    amp_shutdown == (!amp_enable_a && !amp_enable_b))
    else $error("shutdown flag wrong");
  a_running_map: assert property (
    amp_running == (amp_enable_a && amp_enable_b))
    else $error("running flag wrong");
endmodule : avw_slave_sva
bind avw_slave avw_slave_sva chk_u (.clk_sys, .reset_n, .scl_in, .sda_out,
  .sda_oe, .gain_code, .amp_enable_a, .amp_enable_b, .amp_shutdown,
  .amp_running);

// ### bench/avw_master.sv
/*
  bus master model: start, two bytes with ack slots, stop.
  assumes pull-up on data; half periods of 4 clk_sys cycles.
*/
`timescale 1ns/1ns
module avw_master (
  input wire logic clk_sys,
  input wire logic sda_wire,
  output logic     scl_out,
  output logic     sda_pull
);
  // idle: clock high, data released
  initial
  begin
    scl_out = 1'b1;
    sda_pull = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // one clock pulse; data set while clock low, sampled mid high
  task automatic bit_out(input logic b, output logic s);
    scl_out <= 1'b0;
    tick(2);
    sda_pull <= !b;
    tick(2);
    scl_out <= 1'b1;
    tick(2);
    s = sda_wire;
    tick(2);
  endtask : bit_out
  task automatic frame(input logic [6:0] a, input logic rw,
                       input logic [7:0] d, output logic k1, k2);
    logic s;
    sda_pull <= 1'b1;
    tick(4);
    for (int j = 7; j >= 1; j--) bit_out(a[j-1], s);
    bit_out(rw, s);
    bit_out(1'b1, s);
    k1 = !s;
    for (int j = 7; j >= 0; j--) bit_out(d[j], s);
    bit_out(1'b1, s);
    k2 = !s;
    scl_out <= 1'b0;
    tick(2);
    sda_pull <= 1'b1;
    tick(2);
    scl_out <= 1'b1;
    tick(2);
    sda_pull <= 1'b0;
    tick(4);
  endtask : frame
endmodule : avw_master

// ### bench/tb.sv
/*
  testbench: random and corner writes, bad address, read, reset.
  assumes avw_master as bus partner and a pull-up on data.
*/
`timescale 1ns/1ns
module tb;
  logic              clk_sys;
  logic              reset_n;
  logic              scl_in;
  logic              sda_pull;
  logic              sda_out, sda_oe, en_a, en_b, shut, run;
  logic [4:0]        gain_code;
  logic signed [7:0] gain_db;
  logic [7:0]        exp_q;
  logic              k1, k2;
  int                failures = 0, samples_checked = 0, cyc = 0;
  integer            seed;
  wire sda_wire = !((sda_oe && !sda_out) || sda_pull);
  localparam int DB [32] = '{-70, -56, -46, -38, -32, -28, -24, -21, -18,
    -15, -12, -10, -8, -6, -4, -2, 0, 2, 4, 6, 8, 10, 12, 14, 16, 18, 19,
    20, 21, 22, 23, 24};
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  avw_slave dut_u (.clk_sys, .reset_n, .scl_in, .sda_in(sda_wire),
    .sda_out, .sda_oe, .gain_code, .gain_db, .amp_enable_a(en_a),
    .amp_enable_b(en_b), .amp_shutdown(shut), .amp_running(run));
  avw_master mst_u (.clk_sys, .sda_wire, .scl_out(scl_in), .sda_pull);
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // register contents expected after an accepted write: B2 reads as 0
  function automatic logic [7:0] stored_of(input logic [7:0] d);
    return {d[7:3], 1'b0, d[1:0]};
  endfunction : stored_of
  task automatic chk_regs();
    chk("gain_code", {3'h0, gain_code}, {3'h0, exp_q[7:3]});
    chk("gain_db", gain_db, 8'(DB[exp_q[7:3]]));
    chk("en_a", {7'h00, en_a}, {7'h00, exp_q[1]});
    chk("en_b", {7'h00, en_b}, {7'h00, exp_q[0]});
    chk("shut", {7'h00, shut}, {7'h00, exp_q[1:0] == 2'b00});
    chk("run", {7'h00, run}, {7'h00, exp_q[1:0] == 2'b11});
  endtask : chk_regs
  // one frame; expectation from address, direction and reset
  task automatic xfer(input logic [6:0] a, input logic rw,
                      input logic [7:0] d);
    logic ok;
    ok = (a == avw_pkg::SLAVE_ADDR) && !rw && reset_n;
    mst_u.frame(a, rw, d, k1, k2);
    if (ok)
      exp_q = stored_of(d);
    repeat (2) @(posedge clk_sys);
    chk("ack_addr", {7'h00, k1}, {7'h00, ok});
    chk("ack_data", {7'h00, k2}, {7'h00, ok});
    chk_regs();
  endtask : xfer
  task automatic give_verdict();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  // hang guard
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      failures++;
      give_verdict();
    end
  end
  initial
  begin
    seed = 67;
    reset_n = 1'b0;
    exp_q = 8'h00;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk_regs();
    for (int i = 0; i < 32; i++)
      xfer(avw_pkg::SLAVE_ADDR, 1'b0, {5'(i), 3'($random(seed))});
    xfer(avw_pkg::SLAVE_ADDR, 1'b0, 8'hFF);
    xfer(avw_pkg::SLAVE_ADDR, 1'b0, 8'h04);
    for (int i = 0; i < 4; i++)
      xfer(avw_pkg::SLAVE_ADDR ^ {6'($random(seed)), 1'b1}, 1'b0, 8'hFB);
    xfer(avw_pkg::SLAVE_ADDR, 1'b1, 8'($random(seed)));
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    exp_q = 8'h00;
    xfer(avw_pkg::SLAVE_ADDR, 1'b0, 8'hFF);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    xfer(avw_pkg::SLAVE_ADDR, 1'b0, 8'($random(seed)));
    give_verdict();
  end
endmodule : tb
